// ==== verilog/eepc_pkg.sv ====
`default_nettype none
package eepc_pkg;
   // ----------------------------------------
   // Register map and field layout
   // ----------------------------------------
   localparam logic [7:0] CTL_REG_OFS = 8'h1c;
   localparam logic [7:0] CTL_REG_RST = 8'h00;
   localparam int PUMP_EN_BIT = 6;
   localparam int ERASE_HI_BIT = 4;
   localparam int ERASE_LO_BIT = 3;
   localparam int LATCH_BIT = 2;
   localparam int OSC_SEL_BIT = 1;
   localparam int PWR_ON_BIT = 0;
   localparam logic [7:0] CTL_REG_MASK = 8'h5f;
   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   localparam int ARRAY_BYTES = 160;
   localparam int BLOCK_BYTES = 32;
   localparam int ARRAY_AW = 8;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // Erase-mode encodings
   typedef enum logic [1:0] {
      EEPC_NO_ERASE = 2'b00,
      EEPC_BYTE_ERASE = 2'b01,
      EEPC_BLOCK_ERASE = 2'b10,
      EEPC_BULK_ERASE = 2'b11
   } eepc_mode_t;
endpackage
`default_nettype wire

// ==== verilog/eepc_top.sv ====
// Function
// - Block erase clears only the 32-byte block holding the written address.
// - Bulk erase clears all 160 bytes whatever in-range address was written.
// - Latch set routes array buses to programming; clear gives normal reads.
// - Oscillator select 1 picks RC clock, 0 picks CPU clock.
// - Power bit 1 applies pump voltage so program or erase proceeds.
// - Fields: pump 6, erase mode 4 and 3, latch 2, osc 1, power 0.
// - Erased cells read one; programming clears only bits written zero.
`timescale 1ns/100ps
`default_nettype none
module eepc_top #(
   parameter int ARRAY_BYTES = eepc_pkg::ARRAY_BYTES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Array port, address is the offset from the array base
   input wire logic [7:0] arr_addr_i,
   input wire logic [7:0] arr_wdata_i,
   input wire logic arr_wr_i,
   input wire logic arr_rd_i,
   output logic [7:0] arr_rdata_o,
   // Clock source and pump indications
   output logic osc_select_o,
   output logic pump_enable_o,
   output logic prog_power_on_o
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_s1_q, rst_n_q;
   // Two stages so release is clean relative to clk_i
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic [7:0] ctl_q, ctl_d;
   logic [7:0] rdata_q, rdata_d;
   logic sel_ctl;
   assign sel_ctl = (reg_addr_i == eepc_pkg::CTL_REG_OFS);

   // Unused bits 7 and 5 are masked so they always read zero
   always_comb begin
      ctl_d = ctl_q;
      rdata_d = 8'h00;
      if (reg_wr_i && sel_ctl) begin
         ctl_d = reg_wdata_i & eepc_pkg::CTL_REG_MASK;
      end
      if (reg_rd_i && sel_ctl) begin
         rdata_d = ctl_q;
      end else if (reg_rd_i) begin
         rdata_d = 8'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctl_q <= eepc_pkg::CTL_REG_RST;
         rdata_q <= 8'h00;
      end else begin
         ctl_q <= ctl_d;
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata_o = rdata_q;

   logic latch_on, power_on;
   logic [1:0] mode;
   assign latch_on = ctl_q[eepc_pkg::LATCH_BIT];
   assign power_on = ctl_q[eepc_pkg::PWR_ON_BIT];
   assign mode = {ctl_q[eepc_pkg::ERASE_HI_BIT], ctl_q[eepc_pkg::ERASE_LO_BIT]};
   // Clock mux itself lives in the analog section; this is its select
   assign osc_select_o = ctl_q[eepc_pkg::OSC_SEL_BIT];
   assign pump_enable_o = ctl_q[eepc_pkg::PUMP_EN_BIT];
   // Pump voltage is only useful to the array while latched
   assign prog_power_on_o = power_on;

   // ----------------------------------------
   // Target capture
   // ----------------------------------------
   logic [7:0] tgt_addr_q, tgt_addr_d, tgt_data_q, tgt_data_d;
   logic tgt_vld_q, tgt_vld_d;
   // Last in-range write under latch with power off wins; cleared when the latch drops
   always_comb begin
      tgt_addr_d = tgt_addr_q;
      tgt_data_d = tgt_data_q;
      tgt_vld_d = tgt_vld_q && latch_on;
      if (latch_on && arr_wr_i && !power_on &&
          (arr_addr_i < 8'(ARRAY_BYTES))) begin
         tgt_addr_d = arr_addr_i;
         tgt_data_d = arr_wdata_i;
         tgt_vld_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tgt_addr_q <= 8'h00;
         tgt_data_q <= 8'h00;
         tgt_vld_q <= 1'b0;
      end else begin
         tgt_addr_q <= tgt_addr_d;
         tgt_data_q <= tgt_data_d;
         tgt_vld_q <= tgt_vld_d;
      end
   end

   // ----------------------------------------
   // Array cells
   // ----------------------------------------
   // Cells are modelled as settled once power is applied; the pulse
   // length is software's job, so the effect lands on the rising edge
   logic [7:0] mem_q [ARRAY_BYTES];
   logic pwr_prev_q;
   logic fire;
   assign fire = latch_on && power_on && !pwr_prev_q && tgt_vld_q;

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pwr_prev_q <= 1'b0;
      end else begin
         pwr_prev_q <= power_on;
      end
   end

   for (genvar i = 0; i < ARRAY_BYTES; i++) begin : g_cell
      logic [7:0] cell_d;
      logic hit_byte, hit_blk;
      assign hit_byte = (tgt_addr_q == 8'(i));
      assign hit_blk = (tgt_addr_q / 8'(eepc_pkg::BLOCK_BYTES)) ==
                       8'(i / eepc_pkg::BLOCK_BYTES);
      always_comb begin
         cell_d = mem_q[i];
         if (fire) begin
            case (eepc_pkg::eepc_mode_t'(mode))
               eepc_pkg::EEPC_NO_ERASE: begin
                  // Only zeros written take effect
                  if (hit_byte) cell_d = mem_q[i] & tgt_data_q;
               end
               eepc_pkg::EEPC_BYTE_ERASE: begin
                  if (hit_byte) cell_d = eepc_pkg::ERASED_BYTE;
               end
               eepc_pkg::EEPC_BLOCK_ERASE: begin
                  if (hit_blk) cell_d = eepc_pkg::ERASED_BYTE;
               end
               default: begin
                  cell_d = eepc_pkg::ERASED_BYTE;
               end
            endcase
         end
      end
      // Array content survives reset: it is the nonvolatile store
      always_ff @(posedge clk_i) begin
         mem_q[i] <= cell_d;
      end
   end

   // ----------------------------------------
   // Normal reads
   // ----------------------------------------
   logic [7:0] ardata_q, ardata_d;
   // Reads are inhibited while latched, returning zero
   always_comb begin
      ardata_d = 8'h00;
      if (arr_rd_i && !latch_on && (arr_addr_i < 8'(ARRAY_BYTES))) begin
         ardata_d = mem_q[arr_addr_i];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ardata_q <= 8'h00;
      end else begin
         ardata_q <= ardata_d;
      end
   end
   assign arr_rdata_o = ardata_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_arm;
      latch_on && power_on && !pwr_prev_q && tgt_vld_q;
   endsequence

   bulk_all_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      s_arm and (mode == 2'b11) |=> mem_q[ARRAY_BYTES-1] == 8'hff)
      else $error("Bulk erase left last byte set");
   prog_and_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      s_arm and (mode == 2'b00) |=>
      (mem_q[tgt_addr_q] & ~$past(tgt_data_q)) == 8'h00)
      else $error("Programming left a zero bit set");
   blk_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      s_arm and (mode == 2'b10) |=>
      mem_q[($past(tgt_addr_q) / 8'h20) * 8'h20] == 8'hff)
      else $error("Block erase missed block start");
   byte_erase_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      s_arm and (mode == 2'b01) |=> mem_q[tgt_addr_q] == 8'hff)
      else $error("Byte erase failed");
   rd_inhibit_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      arr_rd_i && latch_on |=> arr_rdata_o == 8'h00)
      else $error("Array read not inhibited under latch");
   capture_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      latch_on && arr_wr_i && !power_on && arr_addr_i < 8'(ARRAY_BYTES) |=>
      tgt_addr_q == $past(arr_addr_i) && tgt_vld_q)
      else $error("Array write not captured");
   osc_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      reg_wr_i && sel_ctl |=> osc_select_o == $past(reg_wdata_i[1]))
      else $error("Oscillator select mismatch");
   mask_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      reg_rd_i && sel_ctl |=> (reg_rdata_o & 8'ha0) == 8'h00)
      else $error("Reserved bits read nonzero");
endmodule
`default_nettype wire

// ==== tb/tb_eepc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_eepc_top;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [7:0] arr_addr_i = 8'h00;
   logic [7:0] arr_wdata_i = 8'h00;
   logic arr_wr_i = 1'b0;
   logic arr_rd_i = 1'b0;
   logic [7:0] arr_rdata_o;
   logic osc_select_o;
   logic pump_enable_o;
   logic prog_power_on_o;
   int err_total = 0;
   int num_checks = 0;
   localparam logic [7:0] CTL = eepc_pkg::CTL_REG_OFS;
   // Settling wait after picking the RC clock, arbitrary but nonzero
   localparam int RC_SETTLE = 4;

   eepc_top dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .arr_addr_i(arr_addr_i), .arr_wdata_i(arr_wdata_i),
      .arr_wr_i(arr_wr_i), .arr_rd_i(arr_rd_i), .arr_rdata_o(arr_rdata_o),
      .osc_select_o(osc_select_o), .pump_enable_o(pump_enable_o),
      .prog_power_on_o(prog_power_on_o)
   );

   // ----------------------------------------
   // Clock, checking and closing
   // ----------------------------------------
   // Free-running system clock, 100 ns period
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   // Each task ends one idle edge later so a strobe is never set twice at once
   task automatic rw(logic [7:0] a, logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [7:0] a, logic [7:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk("reg_rdata_o", reg_rdata_o, e);
      @(posedge clk_i);
   endtask

   task automatic awr(logic [7:0] a, logic [7:0] d);
      arr_addr_i <= a;
      arr_wdata_i <= d;
      arr_wr_i <= 1'b1;
      @(posedge clk_i);
      arr_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic ard(logic [7:0] a, logic [7:0] e);
      arr_addr_i <= a;
      arr_rd_i <= 1'b1;
      @(posedge clk_i);
      arr_rd_i <= 1'b0;
      #1;
      chk("arr_rdata_o", arr_rdata_o, e);
      @(posedge clk_i);
   endtask

   // Full software sequence: RC clock and settle, enables and mode, array
   // write, power pulse, power off, then every control bit back to zero.
   // The RC source is picked as a slow bus would need; the power pulse
   // still lasts two bench clock cycles, as set by the rw calls
   task automatic op(logic [1:0] mode, logic [7:0] a, logic [7:0] d);
      logic [7:0] c;
      c = 8'h46 | {3'h0, mode, 3'h0};
      rw(CTL, 8'h02);
      repeat (RC_SETTLE) @(posedge clk_i);
      rw(CTL, c);
      awr(a, d);
      ard(a, 8'h00);
      rw(CTL, c | 8'h01);
      rw(CTL, c);
      rw(CTL, 8'h00);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(CTL, eepc_pkg::CTL_REG_RST);
      rw(CTL, 8'hff);
      rd(CTL, 8'h5f);
      rw(CTL, 8'h03);
      chk("osc_select_o", {7'h0, osc_select_o}, 8'h01);
      chk("prog_power_on_o", {7'h0, prog_power_on_o}, 8'h01);
      chk("pump_enable_o", {7'h0, pump_enable_o}, 8'h00);
      rw(CTL, 8'h40);
      chk("osc_select_o", {7'h0, osc_select_o}, 8'h00);
      chk("pump_enable_o", {7'h0, pump_enable_o}, 8'h01);
      rw(8'h1d, 8'hff);
      rd(8'h1d, 8'h00);
      rd(CTL, 8'h40);
      rw(CTL, 8'h00);
      // Bulk erase from a mid-array address leaves every cell at ones
      op(2'h3, 8'h4d, 8'h12);
      for (int i = 0; i < 160; i++) begin
         ard(i[7:0], eepc_pkg::ERASED_BYTE);
      end
      ard(8'ha0, 8'h00);
      // Programming only ever clears bits written as zero
      op(2'h0, 8'h05, 8'h0f);
      ard(8'h05, 8'h0f);
      op(2'h0, 8'h05, 8'hf3);
      ard(8'h05, 8'h03);
      op(2'h0, 8'h25, 8'h00);
      op(2'h0, 8'h40, 8'h00);
      // A write without the latch is not captured, so no cycle fires
      awr(8'h06, 8'h00);
      rw(CTL, 8'h45);
      rw(CTL, 8'h00);
      ard(8'h06, 8'hff);
      // Block erase at offset 0x32 hits offsets 0x20..0x3f only
      op(2'h2, 8'h32, 8'h00);
      ard(8'h25, 8'hff);
      ard(8'h40, 8'h00);
      ard(8'h05, 8'h03);
      // Byte erase touches the target alone
      op(2'h1, 8'h05, 8'h00);
      ard(8'h05, 8'hff);
      ard(8'h40, 8'h00);
      stop_test();
   end

   // Guard against a hung run
   initial begin
      #5000000;
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
